// *** design/pcgc_top.v ***
// Peripheral clock gate control: module-disable registers, write lock and clock gates
//
// Operation
// - Set disable bit stops that peripheral's clocks.
// - Disabled peripheral ignores writes, reads invalid.
// - One disables, zero enables; reset clears all.
// - Analog, comparator, capture/compare bit placement.
// - Timer, comm, misc bit placement.
// - Locked writes complete normally, change nothing; here they still set the refused flag in the status register.
// - Lock bit twelve blocks disable writes.
// - Lock changes only after unlock sequence.
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcgc_map.vh"

module pcgc_top (
  // Clock, reset, clock enable
  input  wire                     pclk,
  input  wire                     presetn,
  input  wire                     pclk_en,
  // APB slave
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [`PCGC_AW-1:0]      paddr,
  input  wire [`PCGC_DW-1:0]      pwdata,
  input  wire [3:0]               pstrb,
  output reg  [`PCGC_DW-1:0]      prdata,
  output reg                      pready,
  output reg                      pslverr,
  // Peripheral side
  output reg  [`PCGC_NUM_PERIPH-1:0] periph_clk_en,
  output wire [`PCGC_NUM_PERIPH-1:0] periph_clk,
  output reg  [`PCGC_NUM_PERIPH-1:0] periph_reg_block,
  // Lock state
  output reg                      gate_write_lock,
  output wire                     unlock_armed
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire                  setup_ph;
  wire                  access_ph;
  wire                  wr_commit;
  wire [`PCGC_AW-1:0]   gate_off;
  wire                  hit_gate;
  wire [2:0]            gate_idx;
  wire [1:0]            gate_op;
  wire                  hit_cfg;
  wire                  hit_key;
  wire                  hit_stat;
  wire                  hit_any;
  wire [`PCGC_DW-1:0]   byte_mask;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  // A write lands on the edge where the master sees pready high
  assign wr_commit = access_ph & pready & pwrite & pclk_en;

  assign gate_off  = paddr - `PCGC_GATE_FIRST;
  assign hit_gate  = (paddr >= `PCGC_GATE_FIRST) && (paddr <= `PCGC_GATE_LAST);
  assign gate_idx  = gate_off[6:4];
  assign gate_op   = paddr[3:2];
  assign hit_cfg   = (paddr == `PCGC_CFG_OFS);
  assign hit_key   = (paddr == `PCGC_KEY_OFS);
  assign hit_stat  = (paddr == `PCGC_STAT_OFS);
  assign hit_any   = hit_gate | hit_cfg | hit_key | hit_stat;

  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // ----------------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------------
  wire key_wr;
  wire cfg_wr;

  assign key_wr = wr_commit & hit_key;
  assign cfg_wr = wr_commit & hit_cfg;

  pcgc_unlock u_unlock (
    .clk      (pclk),
    .rst_n    (presetn),
    .clk_en   (pclk_en),
    .key_wr   (key_wr),
    .key_data (pwdata),
    .consume  (cfg_wr),
    .armed_q  (unlock_armed)
  );

  // ----------------------------------------------------------------------
  // Configuration control: write lock
  // ----------------------------------------------------------------------
  // A config write without a fresh unlock is dropped, and any config write
  // spends the unlock, so each change needs its own sequence.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_write_lock <= `PCGC_LOCK_RST;
    end else if (cfg_wr && unlock_armed && pstrb[1]) begin
      gate_write_lock <= pwdata[`PCGC_LOCK_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Gate registers
  // ----------------------------------------------------------------------
  wire [`PCGC_DW*`PCGC_GATE_NUM-1:0] gate_flat;
  wire [`PCGC_DW*`PCGC_GATE_NUM-1:0] mask_flat;
  wire                               gate_wr;
  wire                               refused_wr;

  assign mask_flat = {`PCGC_MASK_MISC, `PCGC_MASK_COMM, `PCGC_MASK_TIMER,
                      `PCGC_MASK_CAPCMP, `PCGC_MASK_COMPAR, `PCGC_MASK_ANALOG};

  assign gate_wr    = wr_commit & hit_gate & ~gate_write_lock;
  // Still answered as a normal write, only the contents stay put
  assign refused_wr = wr_commit & hit_gate & gate_write_lock;

  genvar r;
  generate
    for (r = 0; r < `PCGC_GATE_NUM; r = r + 1) begin : g_gate
      wire [`PCGC_DW-1:0] imp;
      reg  [`PCGC_DW-1:0] bits_q;
      reg  [`PCGC_DW-1:0] bits_d;

      assign imp = mask_flat[r*`PCGC_DW +: `PCGC_DW];

      always @* begin
        bits_d = bits_q;
        case (gate_op)
          `PCGC_OP_WR:  bits_d = (bits_q & ~byte_mask) | (pwdata & byte_mask);
          `PCGC_OP_CLR: bits_d = bits_q & ~(pwdata & byte_mask);
          `PCGC_OP_SET: bits_d = bits_q | (pwdata & byte_mask);
          `PCGC_OP_INV: bits_d = bits_q ^ (pwdata & byte_mask);
          default:      bits_d = bits_q;
        endcase
        bits_d = bits_d & imp;
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bits_q <= `PCGC_GATE_RST;
        end else if (gate_wr && (gate_idx == r)) begin
          bits_q <= bits_d;
        end
      end

      assign gate_flat[r*`PCGC_DW +: `PCGC_DW] = bits_q;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Per-peripheral disable vector
  // ----------------------------------------------------------------------
  // Order, bit 0 upward: adc, charge time, comp ref, low volt, comparators,
  // captures, compares, timers, uarts, spis, i2cs, usb, rtc, refclk, parallel.
  wire [`PCGC_DW-1:0]           g_an;
  wire [`PCGC_DW-1:0]           g_cp;
  wire [`PCGC_DW-1:0]           g_cc;
  wire [`PCGC_DW-1:0]           g_tm;
  wire [`PCGC_DW-1:0]           g_cm;
  wire [`PCGC_DW-1:0]           g_ms;
  wire [`PCGC_NUM_PERIPH-1:0]   disable_vec;

  assign g_an = gate_flat[0*`PCGC_DW +: `PCGC_DW];
  assign g_cp = gate_flat[1*`PCGC_DW +: `PCGC_DW];
  assign g_cc = gate_flat[2*`PCGC_DW +: `PCGC_DW];
  assign g_tm = gate_flat[3*`PCGC_DW +: `PCGC_DW];
  assign g_cm = gate_flat[4*`PCGC_DW +: `PCGC_DW];
  assign g_ms = gate_flat[5*`PCGC_DW +: `PCGC_DW];

  assign disable_vec = {
    g_ms[16], g_ms[1], g_ms[0],
    g_cm[24], g_cm[17:16], g_cm[9:8], g_cm[1:0],
    g_tm[4:0],
    g_cc[20:16], g_cc[4:0],
    g_cp[2:0],
    g_an[20], g_an[12], g_an[8], g_an[0]
  };

  // The gating relies on software having stopped the module and, for usb,
  // waited for idle first; nothing here can rescue a module cut mid-work.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clk_en    <= {`PCGC_NUM_PERIPH{1'b1}};
      periph_reg_block <= {`PCGC_NUM_PERIPH{1'b0}};
    end else if (pclk_en) begin
      periph_clk_en    <= ~disable_vec;
      periph_reg_block <= disable_vec;
    end
  end

  // ----------------------------------------------------------------------
  // Clock gates
  // ----------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < `PCGC_NUM_PERIPH; p = p + 1) begin : g_cg
      pcgc_clk_gate u_cg (
        .clk_in  (pclk),
        .rst_n   (presetn),
        .gate_en (periph_clk_en[p]),
        .clk_out (periph_clk[p])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Status: refused-write flag
  // ----------------------------------------------------------------------
  reg refused_q;
  wire stat_clr;

  assign stat_clr = wr_commit & hit_stat & pstrb[0] & pwdata[`PCGC_STAT_REFUSED];

  // Hardware set beats a write-one clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_q <= 1'b0;
    end else if (refused_wr) begin
      refused_q <= 1'b1;
    end else if (stat_clr) begin
      refused_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  reg [`PCGC_DW-1:0] rd_d;

  always @* begin
    rd_d = {`PCGC_DW{1'b0}};
    if (hit_gate) begin
      // Only the plain alias reads back; clear/set/invert read zero
      if (gate_op == `PCGC_OP_WR) begin
        rd_d = gate_flat[gate_idx*`PCGC_DW +: `PCGC_DW];
      end
    end else if (hit_cfg) begin
      rd_d[`PCGC_LOCK_BIT] = gate_write_lock;
    end else if (hit_stat) begin
      rd_d[`PCGC_STAT_LOCK]    = gate_write_lock;
      rd_d[`PCGC_STAT_ARMED]   = unlock_armed;
      rd_d[`PCGC_STAT_REFUSED] = refused_q;
    end
  end

  // ----------------------------------------------------------------------
  // APB response: one wait-free access phase per transfer
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= {`PCGC_DW{1'b0}};
      pslverr <= 1'b0;
    end else if (pclk_en) begin
      if (setup_ph) begin
        pready  <= 1'b1;
        prdata  <= pwrite ? {`PCGC_DW{1'b0}} : rd_d;
        pslverr <= ~hit_any;
      end else begin
        pready  <= 1'b0;
        prdata  <= {`PCGC_DW{1'b0}};
        pslverr <= 1'b0;
      end
    end
  end

endmodule // pcgc_top

`default_nettype wire

// *** design/pcgc_map.vh ***
// Register map, field positions, reset values and keys of the peripheral clock gate control
`ifndef PCGC_MAP_VH
`define PCGC_MAP_VH

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define PCGC_AW              12
`define PCGC_DW              32

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PCGC_CFG_OFS         12'h000
`define PCGC_KEY_OFS         12'h010
`define PCGC_STAT_OFS        12'h020
`define PCGC_GATE_FIRST      12'h240
`define PCGC_GATE_LAST       12'h29C
`define PCGC_GATE_STRIDE     16
`define PCGC_GATE_NUM        6

// Alias of each gate register word: plain, clear, set, invert
`define PCGC_OP_WR           2'd0
`define PCGC_OP_CLR          2'd1
`define PCGC_OP_SET          2'd2
`define PCGC_OP_INV          2'd3

// ----------------------------------------------------------------------
// Implemented bits of the six gate registers
// ----------------------------------------------------------------------
`define PCGC_MASK_ANALOG     32'h0010_1101
`define PCGC_MASK_COMPAR     32'h0000_0007
`define PCGC_MASK_CAPCMP     32'h001F_001F
`define PCGC_MASK_TIMER      32'h0000_001F
`define PCGC_MASK_COMM       32'h0103_0303
`define PCGC_MASK_MISC       32'h0001_0003
`define PCGC_GATE_RST        32'h0000_0000

// ----------------------------------------------------------------------
// Configuration control and status fields
// ----------------------------------------------------------------------
`define PCGC_LOCK_BIT        12
`define PCGC_LOCK_RST        1'b1
`define PCGC_STAT_LOCK       0
`define PCGC_STAT_ARMED      1
`define PCGC_STAT_REFUSED    2

// Unlock keys (values are arbitrary)
`define PCGC_KEY1            32'h3C5A_0F96
`define PCGC_KEY2            32'hC3A5_F069

`define PCGC_NUM_PERIPH      32

`endif

// *** design/pcgc_clk_gate.v ***
// Glitch-free clock gate for one peripheral clock
`timescale 1ns/1ps
`default_nettype none

module pcgc_clk_gate (
  // Clock and reset
  input  wire clk_in,
  input  wire rst_n,
  // Control
  input  wire gate_en,
  // Gated clock
  output wire clk_out
);

  reg en_low_q;

  // Enable only moves on the falling edge, so the AND never clips a high phase
  always @(negedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      en_low_q <= 1'b1;
    end else begin
      en_low_q <= gate_en;
    end
  end

  assign clk_out = clk_in & en_low_q;

endmodule // pcgc_clk_gate

`default_nettype wire

// *** design/pcgc_unlock.v ***
// Two-key unlock sequencer guarding changes of the gate write lock
`timescale 1ns/1ps
`default_nettype none
`include "pcgc_map.vh"

module pcgc_unlock (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clk_en,
  // Key writes
  input  wire        key_wr,
  input  wire [31:0] key_data,
  // Consumed by a configuration write
  input  wire        consume,
  // State
  output reg         armed_q
);

  localparam ST_IDLE = 1'b0;
  localparam ST_KEY1 = 1'b1;

  reg state_q;
  reg state_d;
  reg armed_d;

  always @* begin
    state_d = state_q;
    armed_d = armed_q;
    if (consume) begin
      armed_d = 1'b0;
    end
    if (key_wr) begin
      case (state_q)
        ST_IDLE: begin
          state_d = (key_data == `PCGC_KEY1) ? ST_KEY1 : ST_IDLE;
          armed_d = 1'b0;
        end
        ST_KEY1: begin
          state_d = ST_IDLE;
          armed_d = (key_data == `PCGC_KEY2);
        end
        default: begin
          state_d = ST_IDLE;
          armed_d = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      armed_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      armed_q <= armed_d;
    end
  end

endmodule // pcgc_unlock

`default_nettype wire

// *** verif/pcgc_top_assertions.sv ***
// Concurrent checks on the ports of the peripheral clock gate control
`timescale 1ns/1ps
`default_nettype none
`include "pcgc_map.vh"

module pcgc_top_chk (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [`PCGC_AW-1:0] paddr,
  input wire logic [`PCGC_DW-1:0] prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Gate state
  input wire logic [31:0]         periph_clk_en,
  input wire logic [31:0]         periph_reg_block,
  input wire logic                gate_write_lock,
  input wire logic                unlock_armed
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Transfer phases
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_commit;
    psel && penable && pready && pwrite;
  endsequence
  sequence s_gate_commit;
    s_commit ##0 (paddr >= `PCGC_GATE_FIRST && paddr <= `PCGC_GATE_LAST);
  endsequence

  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("read data not zero while idle");
  a_unmapped_err: assert property (pready && paddr >= 12'h100 && paddr < 12'h240 |-> pslverr)
    else $error("unmapped access without error");
  a_gate_inverse: assert property (periph_clk_en == ~periph_reg_block)
    else $error("clock enable and register block disagree");
  // The lock may only move on a configuration write that follows the key pair
  a_lock_needs_key: assert property ($changed(gate_write_lock) |-> $past(unlock_armed))
    else $error("lock changed without unlock");
  a_armed_consumed: assert property (s_commit ##0 paddr == `PCGC_CFG_OFS |=> !unlock_armed)
    else $error("unlock still armed after config write");
  a_locked_frozen: assert property (gate_write_lock ##0 s_gate_commit
    |=> $stable(periph_reg_block) [*2])
    else $error("locked write changed a gate");
endmodule // pcgc_top_chk

`default_nettype wire

// *** verif/peripheral_clock_gate_ctrl_bench.sv ***
// Self-checking bench for the peripheral clock gate control
`timescale 1ns/1ps
`default_nettype none
`include "pcgc_map.vh"

module peripheral_clock_gate_ctrl_bench;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [31:0] clk_en;
  wire  [31:0] pclk_g;
  wire  [31:0] blk;
  wire         lock;
  wire         armed;
  logic [31:0] rd;
  logic        er;
  int          errors  = 0;
  int          n_tests = 0;
  logic [31:0] mask [6] = '{`PCGC_MASK_ANALOG, `PCGC_MASK_COMPAR, `PCGC_MASK_CAPCMP,
                            `PCGC_MASK_TIMER, `PCGC_MASK_COMM, `PCGC_MASK_MISC};

  always #50 pclk = ~pclk;

  pcgc_top u_dut (
    .pclk(pclk), .presetn(presetn), .pclk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_clk_en(clk_en), .periph_clk(pclk_g), .periph_reg_block(blk),
    .gate_write_lock(lock), .unlock_armed(armed)
  );

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits on pready, bounded by the watchdog as well
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count is assumed here; only the watchdog ends a stalled wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic unlock(input logic [31:0] cfg);
    xfer(1'b1, `PCGC_KEY_OFS, `PCGC_KEY1, 4'hF);
    xfer(1'b1, `PCGC_KEY_OFS, `PCGC_KEY2, 4'hF);
    @(posedge pclk);
    chk32({31'b0, armed}, 32'h1);
    xfer(1'b1, `PCGC_CFG_OFS, cfg, 4'hF);
    @(posedge pclk);
  endtask

  task automatic results;
    $display("Checks %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    results();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk32({31'b0, lock}, 32'h1);
    chk32(clk_en, 32'hFFFF_FFFF);
    // Locked write must finish cleanly yet leave the gates alone
    xfer(1'b1, `PCGC_GATE_FIRST, 32'hFFFF_FFFF, 4'hF);
    chk32({31'b0, er}, 32'h0);
    xfer(1'b0, `PCGC_GATE_FIRST, 32'h0, 4'h0);
    chk32(rd, 32'h0);
    xfer(1'b0, `PCGC_STAT_OFS, 32'h0, 4'h0);
    chk32(rd, 32'h5);
    xfer(1'b1, `PCGC_CFG_OFS, 32'h0, 4'hF);
    @(posedge pclk);
    chk32({31'b0, lock}, 32'h1);
    unlock(32'h0);
    chk32({31'b0, lock}, 32'h0);
    chk32({31'b0, armed}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, `PCGC_GATE_FIRST + 12'(16 * i), 32'hFFFF_FFFF, 4'hF);
      xfer(1'b0, `PCGC_GATE_FIRST + 12'(16 * i), 32'h0, 4'h0);
      chk32(rd, mask[i]);
    end
    repeat (2) @(posedge pclk);
    chk32(clk_en, 32'h0);
    chk32(blk, 32'hFFFF_FFFF);
    // Clear, invert and set aliases
    xfer(1'b1, 12'h244, 32'h0000_0101, 4'hF);
    xfer(1'b1, 12'h27C, 32'h0000_0003, 4'hF);
    xfer(1'b1, 12'h248, 32'h0000_0001, 4'hF);
    xfer(1'b0, 12'h240, 32'h0, 4'h0);
    chk32(rd, 32'h0010_1001);
    xfer(1'b0, 12'h270, 32'h0, 4'h0);
    chk32(rd, 32'h0000_001C);
    repeat (2) @(posedge pclk);
    chk32(clk_en, 32'h0006_0002);
    #20;
    chk32(pclk_g, 32'h0006_0002);
    // Only the top byte lane is written
    xfer(1'b1, 12'h280, 32'h0, 4'h8);
    xfer(1'b0, 12'h280, 32'h0, 4'h0);
    chk32(rd, 32'h0003_0303);
    xfer(1'b1, 12'h100, 32'hFFFF_FFFF, 4'hF);
    chk32({31'b0, er}, 32'h1);
    unlock(32'h0000_1000);
    chk32({31'b0, lock}, 32'h1);
    xfer(1'b1, 12'h290, 32'h0, 4'hF);
    xfer(1'b0, 12'h290, 32'h0, 4'h0);
    chk32(rd, `PCGC_MASK_MISC);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk32(blk, 32'h0);
    presetn <= 1'b1;
    xfer(1'b0, 12'h290, 32'h0, 4'h0);
    chk32(rd, `PCGC_GATE_RST);
    results();
  end
endmodule // peripheral_clock_gate_ctrl_bench

bind pcgc_top pcgc_top_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periph_clk_en(periph_clk_en), .periph_reg_block(periph_reg_block),
  .gate_write_lock(gate_write_lock), .unlock_armed(unlock_armed)
);

`default_nettype wire
